//--- sfs_pkg.sv
// Shared constants and types for the frame status queue block
package sfs_pkg;

  // Queue geometry
  localparam int DEPTH   = 10;
  localparam int CNT_W   = 14;
  localparam int ENTRY_W = 19;
  localparam int PTR_W   = 4;
  localparam int LVL_W   = 4;

  // Register indices, reached through the pointer
  localparam logic [3:0] RI_BASE   = 4'h0;
  localparam logic [3:0] RI_RXSTAT = 4'h1;
  localparam logic [3:0] RI_VEC    = 4'h2;
  localparam logic [3:0] RI_PEND   = 4'h3;
  localparam logic [3:0] RI_MIR4   = 4'h4;
  localparam logic [3:0] RI_MIR5   = 4'h5;
  localparam logic [3:0] RI_CLOW   = 4'h6;
  localparam logic [3:0] RI_CHIGH  = 4'h7;
  localparam logic [3:0] RI_EXT    = 4'hF;
  localparam logic [3:0] WI_CMD    = 4'h0;
  localparam logic [3:0] WI_RXINT  = 4'h1;
  localparam logic [3:0] WI_EXT    = 4'hF;
  localparam logic [3:0] PTR_HIGH  = 4'h8;

  // Field positions
  localparam int EXT_EN_BIT   = 2;
  localparam int CH_OVF_BIT   = 7;
  localparam int CH_AVAIL_BIT = 6;
  localparam int RXINT_LO     = 3;

  // Reset values
  localparam logic [7:0] EXT_RST   = 8'h00;
  localparam logic [7:0] RXINT_RST = 8'h00;
  localparam logic [1:0] RXINT_SPECIAL_ONLY = 2'h3;

  // Command field of the command/pointer register
  typedef enum logic [2:0] {
    CMD_NULL       = 3'b000,
    CMD_POINT_HIGH = 3'b001,
    CMD_ERR_RESET  = 3'b110,
    CMD_CLR_TOP    = 3'b111
  } sfs_cmd_t;

  // One queue entry: byte count and stored status
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [2:0]       residue;
    logic             overrun;
    logic             crc_err;
  } sfs_entry_t;

  // Live receive status in status register bit order
  typedef struct packed {
    logic       eof;
    logic       crc_err;
    logic       overrun;
    logic       parity;
    logic [2:0] residue;
    logic       all_sent;
  } sfs_live_t;

  // Receiver frame events
  typedef struct packed {
    logic byte_stb;
    logic eof_stb;
    logic abort_stb;
  } sfs_rx_ev_t;

  // Character leaving the data FIFO toward the host
  typedef struct packed {
    logic read_stb;
    logic eof;
    logic overrun;
    logic parity;
  } sfs_char_t;

endpackage

//--- sfs_status_queue.sv
// Ten-entry frame status queue storage with pointers
`timescale 1ns/100ps
module sfs_status_queue (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Control
  input  wire logic               clear,
  input  wire logic               push,
  input  wire sfs_pkg::sfs_entry_t push_data,
  input  wire logic               pop,
  // Status
  output sfs_pkg::sfs_entry_t     head,
  output logic                    empty,
  output logic                    full
);
  import sfs_pkg::*;

  sfs_entry_t           mem_reg [DEPTH];
  logic [PTR_W-1:0]     wr_ptr_reg;
  logic [PTR_W-1:0]     rd_ptr_reg;
  logic [LVL_W-1:0]     level_reg;
  logic                 do_push;
  logic                 do_pop;

  // Wrap a pointer at the queue depth
  function automatic logic [PTR_W-1:0] ptr_inc(logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Pop never underflows; push when full is dropped unless a pop in the same cycle frees a slot
  assign empty   = (level_reg == '0);
  assign full    = (level_reg == LVL_W'(DEPTH));
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign head    = mem_reg[rd_ptr_reg];

  // Entry storage
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (do_push && !clear) begin
      mem_reg[wr_ptr_reg] <= push_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else if (clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (do_pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      level_reg <= level_reg + LVL_W'(do_push) - LVL_W'(do_pop);
    end
  end

endmodule

//--- sfs_frame_status.sv
// Receive frame status queue with indirect register access
//
// How it works
// R1: Ten 19-bit entries plus 14-bit byte counter
// R2: Closing flag pushes count and five status
// R3: Receive CRC checker resets after each frame
// R4: Eleventh unread frame end is queue overrun
// R5: Abort also pushes entry and clears counter
// R6: Queue active only when enabled and SDLC
// R7: Pointers clear when disabled; reset disables queue
// R8: Disabled queue mirrors registers zero-three at four-seven
// R9: Readback bit two shows queue enable
// R10: Oldest entry replaces live status when queued
// R11: Status register read removes one entry
// R12: Empty queue switches mux to live status
// R13: High count bit six flags queue not empty
// R14: Entry keeps residue, overrun, CRC only
// R15: Host reads high count, low, then status
// R16: Repeated status reads pop at most once
// R17: High count read latches flag, steers mux
// R18: Push when full sets high count bit seven
// R19: Overflow clears only by enable off-on
// R20: Anti-lock: end-of-frame raises data interrupt
// R21: Host issues clear-top-in-service after service
// R22: Errored character locks FIFO until error reset
`timescale 1ns/100ps
module sfs_frame_status (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rstn,
  // Register port
  input  wire logic               reg_rd,
  input  wire logic               reg_wr,
  input  wire logic               reg_ctrl,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  // Channel mode and live status
  input  wire logic               sdlc_mode,
  input  wire logic [7:0]         live_base,
  input  wire sfs_pkg::sfs_live_t live_stat,
  input  wire logic [7:0]         live_vector,
  input  wire logic [7:0]         live_pending,
  // Receiver events
  input  wire sfs_pkg::sfs_rx_ev_t rx_ev,
  output logic                    crc_reset,
  // Data FIFO side
  input  wire sfs_pkg::sfs_char_t rx_char,
  input  wire logic               top_eof,
  output logic                    rx_fifo_lock,
  // Interrupt side
  input  wire logic               irq_ack,
  output logic                    rx_data_irq,
  output logic                    special_irq,
  output logic                    in_service_latch,
  output logic                    clear_top_in_service_cmd,
  output logic                    queue_active
);
  import sfs_pkg::*;

  logic [3:0]       ptr_reg;
  logic [7:0]       ext_feature_ctrl_reg;
  logic [7:0]       rx_interrupt_ctrl;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic             ovf_reg;
  logic             sel_queue_reg;
  logic             lock_reg;
  logic             special_reg;
  logic             data_irq_reg;
  logic             ius_reg;
  logic             clr_top_reg;
  logic             crc_reset_reg;
  logic [7:0]       rdata_reg;
  logic             ctrl_acc;
  logic [3:0]       acc_idx;
  logic             rd_now;
  logic             wr_now;
  logic             frame_end;
  logic             enable_bit;
  logic             special_only;
  logic             anti_lock;
  logic             q_push;
  logic             q_pop;
  logic             q_clear;
  logic             q_empty;
  logic             q_full;
  sfs_entry_t       q_head;
  sfs_entry_t       push_entry;
  sfs_cmd_t         cmd;
  logic             err_reset;
  logic             clr_top;
  logic             char_err;
  logic             char_lock;
  logic             cmd_wr;
  logic             rd_chigh;
  logic             rd_stat;

  // Access decode: a control access goes to the pointed register
  assign ctrl_acc = reg_ctrl && (reg_rd || reg_wr);
  assign acc_idx  = ptr_reg;
  assign rd_now   = reg_rd && reg_ctrl;
  assign wr_now   = reg_wr && reg_ctrl;
  assign cmd      = sfs_cmd_t'(reg_wdata[5:3]);

  // One register index reached by a strobe in this cycle
  function automatic logic reg_hit(logic stb, logic [3:0] idx,
                                   logic [3:0] want);
    return stb && (idx == want);
  endfunction

  // Commands only when the command register itself is written
  assign cmd_wr    = reg_hit(wr_now, acc_idx, WI_CMD);
  assign rd_chigh  = reg_hit(rd_now, acc_idx, RI_CHIGH);
  assign rd_stat   = reg_hit(rd_now, acc_idx, RI_RXSTAT);
  assign err_reset = cmd_wr && (cmd == CMD_ERR_RESET);
  assign clr_top   = cmd_wr && (cmd == CMD_CLR_TOP);

  // Mode decode
  assign enable_bit   = ext_feature_ctrl_reg[EXT_EN_BIT];
  assign queue_active = enable_bit && sdlc_mode; // R6
  assign special_only =
    (rx_interrupt_ctrl[RXINT_LO+1:RXINT_LO] == RXINT_SPECIAL_ONLY);
  assign anti_lock    = queue_active && special_only; // R20

  // Frame end is a closing flag or an abort
  assign frame_end = rx_ev.eof_stb || rx_ev.abort_stb; // R5

  // Pointer: set by a command register write, cleared after use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ptr_reg <= WI_CMD;
    end else if (ctrl_acc) begin
      if (ptr_reg != WI_CMD) begin
        ptr_reg <= WI_CMD;
      end else if (reg_wr) begin
        ptr_reg <= {(cmd == CMD_POINT_HIGH), reg_wdata[2:0]};
      end
    end
  end

  // Write registers that steer this block
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_feature_ctrl_reg <= EXT_RST; // R7
      rx_interrupt_ctrl    <= RXINT_RST;
    end else if (wr_now) begin
      if (acc_idx == WI_EXT) begin
        ext_feature_ctrl_reg <= reg_wdata;
      end
      if (acc_idx == WI_RXINT) begin
        rx_interrupt_ctrl <= reg_wdata;
      end
    end
  end

  // Byte count for the frame in progress, including a same-cycle byte
  assign count_next = count_reg + CNT_W'(rx_ev.byte_stb);

  // Counter clears at every frame end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else if (frame_end) begin
      count_reg <= '0; // R5
    end else begin
      count_reg <= count_next; // R1
    end
  end

  // Queue entry holds count and the five queued status bits
  always_comb begin
    push_entry.count   = count_next; // R2
    push_entry.residue = live_stat.residue; // R14
    push_entry.overrun = live_stat.overrun;
    push_entry.crc_err = live_stat.crc_err;
  end

  // Queue control
  assign q_push  = queue_active && frame_end; // R2 R5
  assign q_clear = !queue_active; // R7
  assign q_pop   = rd_stat && sel_queue_reg && queue_active; // R11 R16

  sfs_status_queue u_queue (
    .clock     (clock),
    .rstn      (rstn),
    .clear     (q_clear),
    .push      (q_push),
    .push_data (push_entry),
    .pop       (q_pop),
    .head      (q_head),
    .empty     (q_empty),
    .full      (q_full)
  );

  // CRC checker restart pulse after every frame end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crc_reset_reg <= 1'b0;
    end else begin
      crc_reset_reg <= frame_end; // R3
    end
  end

  // Overflow: a push that finds the queue full and nothing leaving
  // A pop in the same cycle makes room, so that push is not lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovf_reg <= 1'b0;
    end else if (!enable_bit) begin
      ovf_reg <= 1'b0; // R19
    end else if (q_push && q_full && !q_pop) begin
      ovf_reg <= 1'b1; // R4 R18
    end
  end

  // Source select latched by the high count read, spent by status read
  // Without this latch a second status read would pop another entry
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_queue_reg <= 1'b0;
    end else if (!queue_active) begin
      sel_queue_reg <= 1'b0;
    end else if (rd_chigh) begin
      sel_queue_reg <= !q_empty; // R17 R12
    end else if (rd_stat) begin
      sel_queue_reg <= 1'b0; // R16
    end
  end

  // Status register view: queued bits or live bits
  function automatic logic [7:0] stat_view(logic use_q,
                                           sfs_entry_t e,
                                           sfs_live_t l);
    sfs_live_t v;
    v = l;
    if (use_q) begin
      v.residue = e.residue; // R10 R14
      v.overrun = e.overrun;
      v.crc_err = e.crc_err;
    end
    return v;
  endfunction

  // Read multiplexer
  function automatic logic [7:0] read_mux(logic [3:0] idx,
                                          logic act,
                                          logic use_q,
                                          sfs_entry_t e,
                                          logic ne,
                                          logic ovf);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      RI_BASE, RI_MIR4: v = live_base; // R8
      RI_RXSTAT, RI_MIR5: v = stat_view(use_q && act, e, live_stat);
      RI_VEC: v = live_vector;
      RI_PEND: v = live_pending;
      RI_CLOW: begin
        if (act) begin
          v = e.count[7:0]; // R10
        end else begin
          v = live_vector; // R8
        end
      end
      RI_CHIGH: begin
        if (act) begin
          v = {ovf, ne, e.count[CNT_W-1:8]}; // R13 R18
        end else begin
          v = live_pending; // R8
        end
      end
      RI_EXT: begin
        v = ext_feature_ctrl_reg;
        v[EXT_EN_BIT] = enable_bit; // R9
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Read data register, loaded on each control read
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 8'h00;
    end else if (rd_now) begin
      rdata_reg <= read_mux(acc_idx, queue_active, sel_queue_reg,
                            q_head, !q_empty, ovf_reg);
    end
  end

  // Character leaving the data FIFO: what locks it
  assign char_err  = rx_char.read_stb
                     && (rx_char.overrun || rx_char.parity);
  assign char_lock = char_err
                     || (rx_char.read_stb && rx_char.eof
                         && special_only && !anti_lock);

  // Data FIFO lock and special interrupt; a new lock beats the reset
  // An error landing with the reset command must not be lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock_reg    <= 1'b0;
      special_reg <= 1'b0;
    end else if (char_lock) begin
      lock_reg    <= 1'b1; // R22
      special_reg <= 1'b1; // R22
    end else if (err_reset) begin
      lock_reg    <= 1'b0;
      special_reg <= 1'b0;
    end
  end

  // In anti-lock mode, end-of-frame at FIFO top gives the receive-data interrupt
  // Held off while the host still services an earlier interrupt
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_irq_reg <= 1'b0;
    end else begin
      data_irq_reg <= anti_lock && top_eof && !ius_reg; // R20
    end
  end

  // In-service latch, cleared by the clear-top command
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ius_reg     <= 1'b0;
      clr_top_reg <= 1'b0;
    end else begin
      clr_top_reg <= clr_top; // R21
      if (irq_ack) begin
        ius_reg <= 1'b1;
      end else if (clr_top) begin
        ius_reg <= 1'b0;
      end
    end
  end

  // Outputs
  assign reg_rdata                = rdata_reg;
  assign crc_reset                = crc_reset_reg;
  assign rx_fifo_lock             = lock_reg;
  assign rx_data_irq              = data_irq_reg;
  assign special_irq              = special_reg;
  assign in_service_latch         = ius_reg;
  assign clear_top_in_service_cmd = clr_top_reg;

endmodule

//--- sfs_frame_status_assertions.sv
// Port checks for the frame status queue block
`timescale 1ns/100ps
module sfs_frame_status_assertions (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rstn,
  // Register port
  input wire logic                reg_rd,
  input wire logic                reg_wr,
  input wire logic                reg_ctrl,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  // Receive and interrupt side
  input wire logic [7:0]          live_base,
  input wire sfs_pkg::sfs_rx_ev_t rx_ev,
  input wire sfs_pkg::sfs_char_t  rx_char,
  input wire logic                irq_ack,
  input wire logic                crc_reset,
  input wire logic                rx_fifo_lock,
  input wire logic                in_service_latch,
  input wire logic                clear_top_in_service_cmd,
  input wire logic                queue_active
);
  import sfs_pkg::*;
  logic [3:0] ptr_reg;
  logic [3:0] qcnt_reg;
  logic       armed_reg;
  logic       ovf_reg;
  // Decoded accesses and queue traffic
  wire logic       rd_hit  = reg_ctrl & reg_rd;
  wire logic       cmd_hit = reg_ctrl & reg_wr & (ptr_reg == WI_CMD);
  wire logic       fend    = rx_ev.eof_stb | rx_ev.abort_stb;
  wire logic       pop     = rd_hit & (ptr_reg == RI_RXSTAT) & armed_reg;
  wire logic       push    = queue_active & fend;
  wire logic [1:0] flags   = {ovf_reg, qcnt_reg != 4'h0};
  // Register pointer, back to zero after each use
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      ptr_reg <= 4'h0;
    else if (cmd_hit)
      ptr_reg <= {reg_wdata[5:3] == 3'h1, reg_wdata[2:0]};
    else if (reg_ctrl & (reg_rd | reg_wr))
      ptr_reg <= 4'h0;
  end
  // Expected occupancy, overflow and latched source select
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      qcnt_reg <= 4'h0;
      armed_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else if (!queue_active) begin
      qcnt_reg <= 4'h0;
      armed_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      if (push && !pop && qcnt_reg == 4'(DEPTH))
        ovf_reg <= 1'b1;
      qcnt_reg <= qcnt_reg - 4'(pop)
                  + 4'(push && (pop || qcnt_reg != 4'(DEPTH)));
      if (rd_hit && ptr_reg == RI_CHIGH)
        armed_reg <= qcnt_reg != 4'h0;
      else if (rd_hit && ptr_reg == RI_RXSTAT)
        armed_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_crc_pulse; fend |=> crc_reset; endproperty
  a_crc_pulse: assert property (p_crc_pulse)
    else $error("no crc reset after frame end");
  property p_crc_cause; crc_reset |-> $past(fend); endproperty
  a_crc_cause: assert property (p_crc_cause)
    else $error("crc reset without frame end");
  property p_ext_rd;
    rd_hit && ptr_reg == RI_EXT && queue_active |=> reg_rdata[EXT_EN_BIT];
  endproperty
  a_ext_rd: assert property (p_ext_rd)
    else $error("enable readback low while active");
  property p_mirror;
    rd_hit && ptr_reg == RI_MIR4 && !queue_active
      |=> reg_rdata == $past(live_base);
  endproperty
  a_mirror: assert property (p_mirror)
    else $error("index four does not mirror index zero");
  property p_flags;
    rd_hit && ptr_reg == RI_CHIGH && queue_active
      |=> reg_rdata[7:6] == $past(flags);
  endproperty
  a_flags: assert property (p_flags)
    else $error("high count flags wrong");
  property p_clr_top;
    cmd_hit && reg_wdata[5:3] == 3'h7 && !irq_ack
      |=> clear_top_in_service_cmd && !in_service_latch;
  endproperty
  a_clr_top: assert property (p_clr_top)
    else $error("clear top command not applied");
  property p_lock;
    rx_char.read_stb && (rx_char.overrun || rx_char.parity) |=> rx_fifo_lock;
  endproperty
  a_lock: assert property (p_lock)
    else $error("errored character did not lock");
  property p_err_clr;
    cmd_hit && reg_wdata[5:3] == 3'h6 && !rx_char.read_stb |=> !rx_fifo_lock;
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("error reset did not unlock");
endmodule
bind sfs_frame_status sfs_frame_status_assertions i_chk (.*);

//--- sfs_host_model.sv
// Host processor model for the indirect register port
`timescale 1ns/100ps
module sfs_host_model (
  // Clock
  input  wire logic       clock,
  // Register port
  output logic            reg_rd,
  output logic            reg_wr,
  output logic            reg_ctrl,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  import sfs_pkg::*;
  // Idle bus at time zero
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_ctrl = 1'b0;
    reg_wdata = 8'h00;
  end
  // One control strobe, launched after an edge, held through the next
  task automatic strobe(input logic [7:0] val, input logic rd);
    @(posedge clock);
    #2;
    reg_ctrl = 1'b1;
    reg_rd = rd;
    reg_wr = !rd;
    reg_wdata = val;
    @(posedge clock);
    #2;
    reg_ctrl = 1'b0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = ~val; // Released bus keeps no old value
  endtask
  // Pointer write; index zero needs none
  task automatic point(input logic [3:0] idx);
    if (idx != 4'h0)
      strobe({4'h0, idx}, 1'b0);
  endtask
  task automatic wr_reg(input logic [3:0] idx, input logic [7:0] val);
    point(idx);
    strobe(val, 1'b0);
  endtask
  task automatic rd_reg(input logic [3:0] idx, output logic [7:0] val);
    point(idx);
    strobe(8'h00, 1'b1);
    val = reg_rdata;
  endtask
  // Count before status, since the status read pops the entry
  task automatic read_entry(output logic [7:0] hi, lo, st);
    rd_reg(RI_CHIGH, hi);
    rd_reg(RI_CLOW, lo);
    rd_reg(RI_RXSTAT, st);
  endtask
endmodule

//--- sfs_frame_status_tb.sv
// Self-checking bench for the frame status queue block
`timescale 1ns/100ps
module sfs_frame_status_tb;
  import sfs_pkg::*;
  // Live values seen by the host
  localparam logic [7:0] BASE_V = 8'hA5;
  localparam logic [7:0] VEC_V  = 8'h3C;
  localparam logic [7:0] PEND_V = 8'h5A;
  localparam logic [7:0] RD_ST  = 8'h91; // End of frame, parity, all sent
  // Queue off: index read and value expected
  localparam logic [11:0] ROWS [9] = '{
    {RI_BASE, BASE_V}, {RI_RXSTAT, RD_ST}, {RI_VEC, VEC_V},
    {RI_PEND, PEND_V}, {RI_MIR4, BASE_V}, {RI_MIR5, RD_ST},
    {RI_CLOW, VEC_V}, {RI_CHIGH, PEND_V}, {RI_EXT, EXT_RST}};
  // Frame: bytes, status, abort, then high, low, status read back
  localparam logic [48:0] FRAMES [3] = '{
    {16'd3, 8'h4A, 1'b0, 8'h40, 8'h03, 8'hDB},
    {16'd300, 8'h24, 1'b1, 8'h41, 8'h2C, 8'hB5},
    {16'd1, 8'h00, 1'b0, 8'h40, 8'h01, 8'h91}};
  logic       clock, rstn, sdlc_mode, top_eof, irq_ack;
  logic       reg_rd, reg_wr, reg_ctrl, crc_reset, rx_fifo_lock;
  logic       rx_data_irq, special_irq, in_service_latch, queue_active;
  logic       clear_top_in_service_cmd;
  logic [7:0] reg_wdata, reg_rdata, live_base, live_vector, live_pending;
  logic [7:0] d, hi, lo, st;
  sfs_live_t  live_stat;
  sfs_rx_ev_t rx_ev;
  sfs_char_t  rx_char;
  int         mismatches, cmp_count;
  sfs_frame_status i_dut (.*);
  sfs_host_model i_host (.*);
  // Clock at 40 MHz
  always #12.5 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One edge later, after the drive delay
  task automatic step();
    @(posedge clock);
    #2;
  endtask
  // Frame of n bytes, closed by flag or abort
  task automatic frame(input int n, input logic [7:0] stat, input logic ab);
    step();
    live_stat = stat;
    rx_ev = 3'b100;
    repeat (n) @(posedge clock);
    #2;
    rx_ev = ab ? 3'b001 : 3'b010;
    step();
    check({7'h0, crc_reset}, 8'h01);
    rx_ev = 3'b000;
    live_stat = RD_ST;
  endtask
  // Main sequence
  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    sdlc_mode = 1'b1;
    top_eof = 1'b0;
    irq_ack = 1'b0;
    live_base = BASE_V;
    live_vector = VEC_V;
    live_pending = PEND_V;
    live_stat = RD_ST;
    rx_ev = 3'b000;
    rx_char = 4'h0;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(posedge clock);
    #2;
    rstn = 1'b1;
    foreach (ROWS[i]) begin
      i_host.rd_reg(ROWS[i][11:8], d);
      check(d, ROWS[i][7:0]);
    end
    $display("test mirror done");
    i_host.wr_reg(WI_EXT, 8'h04);
    check({7'h0, queue_active}, 8'h01);
    sdlc_mode = 1'b0;
    step();
    check({7'h0, queue_active}, 8'h00);
    sdlc_mode = 1'b1;
    i_host.rd_reg(RI_EXT, d);
    check(d, 8'h04);
    $display("test enable done");
    foreach (FRAMES[i])
      frame(FRAMES[i][48:33], FRAMES[i][32:25], FRAMES[i][24]);
    foreach (FRAMES[i]) begin
      i_host.read_entry(hi, lo, st);
      check(hi, FRAMES[i][23:16]);
      check(lo, FRAMES[i][15:8]);
      check(st, FRAMES[i][7:0]);
      i_host.rd_reg(RI_RXSTAT, d);
      check(d, RD_ST);
    end
    i_host.rd_reg(RI_CHIGH, d);
    check(d & 8'hC0, 8'h00);
    $display("test frames done");
    repeat (10) frame(1, 8'h00, 1'b0);
    i_host.rd_reg(RI_CHIGH, d);
    check(d, 8'h40);
    frame(1, 8'h00, 1'b0);
    i_host.rd_reg(RI_CHIGH, d);
    check(d & 8'hC0, 8'hC0);
    i_host.wr_reg(WI_EXT, 8'h00);
    i_host.wr_reg(WI_EXT, 8'h04);
    i_host.rd_reg(RI_CHIGH, d);
    check(d & 8'hC0, 8'h00);
    $display("test overflow done");
    i_host.wr_reg(WI_RXINT, 8'h18);
    step();
    rx_char = 4'b1100;
    top_eof = 1'b1;
    step();
    rx_char = 4'b0000;
    check({7'h0, rx_fifo_lock}, 8'h00);
    step();
    check({7'h0, rx_data_irq}, 8'h01);
    irq_ack = 1'b1;
    top_eof = 1'b0;
    step();
    irq_ack = 1'b0;
    check({7'h0, in_service_latch}, 8'h01);
    i_host.wr_reg(WI_CMD, 8'h38);
    check({7'h0, clear_top_in_service_cmd}, 8'h01);
    check({7'h0, in_service_latch}, 8'h00);
    step();
    rx_char = 4'b1010;
    step();
    rx_char = 4'b0000;
    check({6'h0, rx_fifo_lock, special_irq}, 8'h03);
    i_host.wr_reg(WI_CMD, 8'h30);
    check({6'h0, rx_fifo_lock, special_irq}, 8'h00);
    i_host.wr_reg(WI_EXT, 8'h00);
    rx_char = 4'b1100;
    step();
    rx_char = 4'b0000;
    check({7'h0, rx_fifo_lock}, 8'h01);
    i_host.wr_reg(WI_CMD, 8'h30);
    check({7'h0, rx_fifo_lock}, 8'h00);
    $display("test interrupts done");
    rstn = 1'b0;
    step();
    check({7'h0, queue_active}, 8'h00);
    rstn = 1'b1;
    i_host.rd_reg(RI_EXT, d);
    check(d, EXT_RST);
    $display("test reset done");
    tally_and_finish();
  end
  // Watchdog at 10000 cycles, well past the few hundred cycles needed
  initial begin
    #250000;
    mismatches++;
    tally_and_finish();
  end
endmodule
